//--- rtl/fmfc_core.sv
`include "fmfc_regs.svh"
//
// Contract
// - Coefficients round to 12 bits toward zero; negatives add or of low nibble.
// - Multiplier gives full 28-bit product of data and 12-bit coefficient.
// - Product loses four lsbs, then 24 bits sign extend to 32.
// - Accumulator is 32 bits, ten integer bits, all bits on result.
// - Dual cascaded mode feeds middle sixteen accumulator bits to network two.
// - Two-bit field gives chain role: interface, termination or intermediate.
// - Reduced rate cascade: data passes one way, partial sums the other.
// - Device outputs delayed copy of filter-go for the next device.
// - Full rate cascade: data and sums same direction, shared global go.
// - Full rate latency: termination 12, interface 8, intermediate 4 cycles.
// - At most 128 coefficients; 128 taps forbid decimate and bank swap.
// - 64 taps allow decimate or swap, not both; shorter allow all.
// - ROM load with free start high runs once loading completes.
// - Sample strobe marks new input wanted and new result ready.
// - Free start low: filtering waits for a high on filter-go.
// - Control register resets to 8c80: single, full rate, standalone.
// - Control bit picks bank source: swap pin or register bit.
// - Low bank source uses lower banks, high uses upper, all at once.
// - Bank change lands at next sample edge, up to eight clocks later.
// - Control bit 15 selects single mode; bits 14:13 set MAC reuse.
// - Control bit 12 selects decimate by two, doubling filter length.
module fmfc_core (
    input  wire logic        ref_clk,
    input  wire logic        reset,
    input  wire logic        controlWrite,
    input  wire logic [15:0] controlData,
    input  wire logic        coefWrite,
    input  wire logic [6:0]  coefAddr,
    input  wire logic [15:0] coefData,
    input  wire logic        loadDone,
    input  wire logic        romLoadSelect,
    input  wire logic        freeStartSelect,
    input  wire logic        filterGoInput,
    input  wire logic        swapPin,
    input  wire logic [15:0] dataIn,
    input  wire logic [15:0] casDataIn,
    input  wire logic [31:0] casSumIn,
    output logic      [31:0] resultOut,
    output logic      [15:0] casDataOut,
    output logic             sampleStrobeOut,
    output logic             delayedGoOutput,
    output logic             running,
    output logic             configError,
    output logic             bankActive,
    output logic      [15:0] controlOut
);
    localparam int PW = 69;

    logic [PW-1:0]          pinMeta;
    logic [PW-1:0]          pinSync;
    logic [15:0]            dataSync;
    logic [15:0]            casDataSync;
    logic [31:0]            casSumSync;
    logic                   goSync;
    logic                   freeSync;
    logic                   swapSync;
    logic                   romSync;
    logic                   doneSync;
    logic [15:0]            ctrlReg;
    logic [11:0]            coefMem [0:`FMFC_COEF_DEPTH-1];
    logic [11:0]            coefRound;
    logic [15:0]            lineData [0:`FMFC_LINE_LEN-1];
    logic [31:0]            macTerm [0:`FMFC_MACS-1];
    logic [31:0]            chainA [0:`FMFC_MACS];
    logic [31:0]            accA;
    logic [31:0]            accB;
    logic [15:0]            feedHold; // network a result held for the next shift
    logic [31:0]            resPipe [0:`FMFC_LAT_TERM-1];
    logic [3:0]             phase;
    fmfc_pkg::fmfc_state_t  state;
    fmfc_pkg::fmfc_state_t  next_state;

    // two-flop synchroniser for data, cascade, go, start, swap and load pins; not control or coefficient writes
    always_ff @(posedge ref_clk) begin
        pinMeta <= {dataIn, casDataIn, casSumIn, filterGoInput, freeStartSelect,
                    swapPin, romLoadSelect, loadDone};
        pinSync <= pinMeta;
    end

    assign {dataSync, casDataSync, casSumSync, goSync, freeSync,
            swapSync, romSync, doneSync} = pinSync;

    // control field decode
    wire        singleMode = ctrlReg[`FMFC_BIT_SINGLE];
    wire [1:0]  rateSel    = ctrlReg[`FMFC_RATE_HI:`FMFC_RATE_LO];
    wire        dualCas    = !singleMode && ctrlReg[`FMFC_BIT_DUAL_CAS];
    wire        decimate   = singleMode && ctrlReg[`FMFC_BIT_DECIMATE];
    wire        fullRate   = (rateSel == 2'b00);
    wire        bankSrc    = ctrlReg[`FMFC_BIT_BANK_SRC];
    fmfc_pkg::fmfc_role_t role;
    assign role = fmfc_pkg::fmfc_role_t'(ctrlReg[`FMFC_ROLE_HI:`FMFC_ROLE_LO]);
    wire        cascaded   = singleMode && (role != fmfc_pkg::FMFC_ROLE_ALONE);

    // reuse count, taps per network and coefficient demand
    wire [3:0]  reuse      = 4'h1 << rateSel;
    wire [4:0]  periodLen  = {1'b0, reuse} << decimate;
    wire [8:0]  taps       = dualCas ? {2'h0, reuse, 3'h0} : {periodLen, 4'h0};
    wire [8:0]  netCoefs   = dualCas ? {taps[7:0], 1'b0} : taps;
    wire        bankReq    = bankSrc ? ctrlReg[`FMFC_BIT_BANK_SEL] : swapSync;
    wire        lenBad     = (netCoefs > 9'h080);
    wire        swapBad    = ({netCoefs[7:0], 1'b0} > 9'h080) || netCoefs[8];
    wire        bankReqOk  = bankReq && !swapBad;

    // phase decode
    wire [2:0]  blk        = phase[2:0] & (reuse[2:0] - 3'h1);
    wire        inLast     = (blk == reuse[2:0] - 3'h1);
    wire        outLast    = ({1'b0, phase} == periodLen - 5'h01);
    wire        highHalf   = decimate && ({1'b0, phase} < {1'b0, reuse});
    wire        startNow   = (state != fmfc_pkg::FMFC_ST_RUN) && (next_state == fmfc_pkg::FMFC_ST_RUN);
    wire        shiftNow   = startNow || (running && inLast);
    wire        latchNow   = running && outLast;

    // input source: chain start takes the pins, others the neighbour
    wire        takePins   = !cascaded || (fullRate ? role == fmfc_pkg::FMFC_ROLE_TERM
                                                    : role == fmfc_pkg::FMFC_ROLE_IFACE);
    wire [15:0] newSample  = takePins ? dataSync : casDataSync;
    wire        addCas     = cascaded && (role != fmfc_pkg::FMFC_ROLE_TERM);
    wire [31:0] casAdd     = addCas ? casSumSync : 32'h0000_0000;
    wire [15:0] feed       = feedHold;

    // tap number of one mac in the current cycle
    function automatic logic [6:0] tapOf(input int k, input logic [2:0] b, input logic dual,
                                         input logic hi, input logic [3:0] ru);
        logic [6:0] j;
        j = 7'h00;
        if (dual) begin
            j = 7'((k % 8) + 8 * b) + ((k >= 8) ? 7'd64 : 7'd0);
        end else begin
            j = 7'(k + 16 * b) + (hi ? 7'({ru, 4'h0}) : 7'h00);
        end
        return j;
    endfunction

    // sixteen macs with their data and coefficient selection
    assign chainA[0] = 32'h0000_0000;
    generate
        for (genvar k = 0; k < `FMFC_MACS; k++) begin : g_mac
            wire [6:0] tapK  = tapOf(k, blk, dualCas, highHalf, reuse);
            wire [6:0] dIdx  = tapK - {6'h00, highHalf};
            wire [6:0] cIdx  = tapK + (bankActive ? taps[6:0] : 7'h00);
            fmfc_mac u_mac (
                .sample (lineData[dIdx]),
                .coef   (coefMem[cIdx]),
                .term   (macTerm[k])
            );
            assign chainA[k+1] = chainA[k] + macTerm[k];
        end
    endgenerate

    // network sums; dual mode splits the macs in two halves
    wire [31:0] sumHi      = chainA[16] - chainA[8];
    wire [31:0] sumA       = dualCas ? chainA[8] : chainA[16];
    wire [31:0] resultNow  = dualCas ? accB + sumHi : accA + sumA + casAdd;
    wire [31:0] accANext   = accA + sumA;

    // role latency in a full rate cascade
    wire [3:0]  latDepth   = (role == fmfc_pkg::FMFC_ROLE_TERM)  ? 4'(`FMFC_LAT_TERM)  :
                             (role == fmfc_pkg::FMFC_ROLE_IFACE) ? 4'(`FMFC_LAT_IFACE) :
                                                                   4'(`FMFC_LAT_INTER);
    wire        pipeMode   = cascaded && fullRate;
    wire [31:0] pipeOut    = resPipe[latDepth - 4'h2];

    // run control state
    always_comb begin
        next_state = state;
        case (state)
            fmfc_pkg::FMFC_ST_LOAD: begin
                if (doneSync && romSync && freeSync) begin
                    next_state = fmfc_pkg::FMFC_ST_RUN;
                end else if (doneSync) begin
                    next_state = fmfc_pkg::FMFC_ST_WAIT;
                end
            end
            fmfc_pkg::FMFC_ST_WAIT: begin
                if (goSync) begin
                    next_state = fmfc_pkg::FMFC_ST_RUN;
                end
            end
            fmfc_pkg::FMFC_ST_RUN: begin
                next_state = fmfc_pkg::FMFC_ST_RUN;
            end
            default: begin
                next_state = fmfc_pkg::FMFC_ST_LOAD;
            end
        endcase
    end

    // state, control register and go relay
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            state           <= fmfc_pkg::FMFC_ST_LOAD;
            ctrlReg         <= `FMFC_CTRL_RESET;
            delayedGoOutput <= 1'b0;
            running         <= 1'b0;
        end else begin
            state           <= next_state;
            running         <= (next_state == fmfc_pkg::FMFC_ST_RUN);
            delayedGoOutput <= goSync || startNow;
            if (controlWrite) begin
                ctrlReg <= controlData;
            end
        end
    end

    assign controlOut = ctrlReg;

    // coefficient store, rounded on write
    fmfc_coef_round u_round (
        .coefIn  (coefData),
        .coefOut (coefRound)
    );

    always_ff @(posedge ref_clk) begin
        if (coefWrite) begin
            coefMem[coefAddr] <= coefRound;
        end
    end

    // sample delay line; in dual mode entry 64 starts network two
    always_ff @(posedge ref_clk) begin
        if (shiftNow) begin
            lineData[0] <= newSample;
        end
    end

    generate
        for (genvar i = 1; i < `FMFC_LINE_LEN; i++) begin : g_line
            always_ff @(posedge ref_clk) begin
                if (shiftNow) begin
                    lineData[i] <= (dualCas && i == `FMFC_NET_BASE) ? feed : lineData[i-1];
                end
            end
        end
    endgenerate

    // result pipeline for full rate cascade
    always_ff @(posedge ref_clk) begin
        resPipe[0] <= resultNow;
    end

    generate
        for (genvar i = 1; i < `FMFC_LAT_TERM; i++) begin : g_pipe
            always_ff @(posedge ref_clk) begin
                resPipe[i] <= resPipe[i-1];
            end
        end
    endgenerate

    // phase, accumulators, bank and outputs
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            phase           <= 4'h0;
            accA            <= 32'h0000_0000;
            accB            <= 32'h0000_0000;
            bankActive      <= 1'b0;
            configError     <= 1'b0;
            sampleStrobeOut <= 1'b0;
            resultOut       <= 32'h0000_0000;
            casDataOut      <= 16'h0000;
        end else begin
            configError     <= lenBad || (bankReq && swapBad);
            sampleStrobeOut <= shiftNow;
            if (startNow || latchNow) begin
                phase <= 4'h0;
            end else if (running) begin
                phase <= phase + 4'h1;
            end
            if (shiftNow) begin
                bankActive <= bankReqOk;
                casDataOut <= lineData[taps[6:0] - 7'h01];
            end
            if (latchNow || startNow) begin
                feedHold <= accANext[`FMFC_FEED_LSB+15:`FMFC_FEED_LSB];
                accA     <= 32'h0000_0000;
                accB     <= 32'h0000_0000;
            end else if (running) begin
                accA <= accANext;
                accB <= accB + sumHi;
            end
            if (pipeMode && running) begin
                resultOut <= pipeOut;
            end else if (latchNow) begin
                resultOut <= resultNow;
            end
        end
    end

    // checks on arithmetic, start and bank control
    logic signed [16:0] roundErr;
    assign roundErr = $signed({coefData[15], coefData}) - $signed({coefRound[11], coefRound, 4'h0});

    property p_round;
        @(posedge ref_clk) disable iff (reset)
        coefWrite |-> (coefData[15] ? (roundErr <= 0 && roundErr > -17'sd16)
                                    : (roundErr >= 0 && roundErr < 17'sd16));
    endproperty
    a_round: assert property (p_round) else $error("coefficient rounding wrong");

    property p_mac;
        @(posedge ref_clk) disable iff (reset)
        running |-> $signed(macTerm[0]) ==
            32'(($signed(lineData[g_mac[0].dIdx]) * $signed(coefMem[g_mac[0].cIdx])) >>> 4);
    endproperty
    a_mac: assert property (p_mac) else $error("mac term wrong");

    property p_result;
        @(posedge ref_clk) disable iff (reset)
        latchNow && !pipeMode |=> resultOut == $past(resultNow);
    endproperty
    a_result: assert property (p_result) else $error("result not presented");
    property p_feed;
        @(posedge ref_clk) disable iff (reset)
        shiftNow && dualCas |=> lineData[`FMFC_NET_BASE] == $past(feed);
    endproperty
    a_feed: assert property (p_feed) else $error("cascade feed wrong");
    property p_relay;
        @(posedge ref_clk) disable iff (reset)
        goSync |=> delayedGoOutput;
    endproperty
    a_relay: assert property (p_relay) else $error("go not relayed");
    property p_term_lat;
        @(posedge ref_clk) disable iff (reset)
        (running && pipeMode && role == fmfc_pkg::FMFC_ROLE_TERM)[*8] ##0 $stable(ctrlReg)
            |-> ##12 (!running || ctrlReg != $past(ctrlReg, 12)
                      || resultOut == $past(resultNow, 12));
    endproperty
    a_term_lat: assert property (p_term_lat) else $error("termination latency wrong");

    property p_no_swap;
        @(posedge ref_clk) disable iff (reset)
        swapBad && shiftNow |=> !bankActive ##1 configError || !bankReq;
    endproperty
    a_no_swap: assert property (p_no_swap) else $error("illegal bank swap taken");

    sequence s_free_ready;
        state == fmfc_pkg::FMFC_ST_LOAD && doneSync && romSync && freeSync;
    endsequence
    property p_free;
        @(posedge ref_clk) disable iff (reset)
        s_free_ready |=> running && sampleStrobeOut;
    endproperty
    a_free: assert property (p_free) else $error("free start missed");

    sequence s_waiting;
        state == fmfc_pkg::FMFC_ST_WAIT && !goSync;
    endsequence
    property p_hold;
        @(posedge ref_clk) disable iff (reset)
        s_waiting |=> !running;
    endproperty
    a_hold: assert property (p_hold) else $error("ran without go");

    property p_reset;
        @(posedge ref_clk)
        reset |=> ctrlReg == `FMFC_CTRL_RESET && !running;
    endproperty
    a_reset: assert property (p_reset) else $error("control reset wrong");

    property p_bank;
        @(posedge ref_clk) disable iff (reset)
        shiftNow |=> bankActive == $past(bankReqOk);
    endproperty
    a_bank: assert property (p_bank) else $error("bank change wrong");
endmodule

//--- shared/fmfc_regs.svh
`ifndef FMFC_REGS_SVH
`define FMFC_REGS_SVH

// control register reset value and field positions
`define FMFC_CTRL_RESET     16'h8c80
`define FMFC_BIT_SINGLE     15
`define FMFC_RATE_HI        14
`define FMFC_RATE_LO        13
`define FMFC_BIT_DECIMATE   12
`define FMFC_ROLE_HI        11
`define FMFC_ROLE_LO        10
`define FMFC_BIT_BANK_SRC   7
`define FMFC_BIT_BANK_SEL   6
`define FMFC_BIT_DUAL_CAS   4

// storage and array sizes
`define FMFC_COEF_DEPTH     128
`define FMFC_LINE_LEN       128
`define FMFC_MACS           16
`define FMFC_NET_BASE       64
`define FMFC_FEED_LSB       8

// full-rate cascade latency contributions, system clocks
`define FMFC_LAT_TERM       12
`define FMFC_LAT_IFACE      8
`define FMFC_LAT_INTER      4

// least reset hold, system clocks
`define FMFC_RESET_MIN      16

`endif

//--- shared/fmfc_pkg.sv
package fmfc_pkg;

    // position of the device in a cascade chain
    typedef enum logic [1:0] {
        FMFC_ROLE_INTER = 2'b00,
        FMFC_ROLE_TERM  = 2'b01,
        FMFC_ROLE_IFACE = 2'b10,
        FMFC_ROLE_ALONE = 2'b11
    } fmfc_role_t;

    // run control
    typedef enum logic [1:0] {
        FMFC_ST_LOAD = 2'b00,
        FMFC_ST_WAIT = 2'b01,
        FMFC_ST_RUN  = 2'b10
    } fmfc_state_t;

endpackage

//--- rtl/fmfc_coef_round.sv
// 16-bit coefficient to 12 bits, rounding toward zero
module fmfc_coef_round (
    input  wire logic [15:0] coefIn,
    output logic      [11:0] coefOut
);
    // negative values add the or of the dropped bits
    assign coefOut = coefIn[15] ? coefIn[15:4] + {11'h000, |coefIn[3:0]}
                                : coefIn[15:4];
endmodule

//--- rtl/fmfc_mac.sv
// one multiplier: full product, truncated and sign extended for the adder
module fmfc_mac (
    input  wire logic [15:0] sample,
    input  wire logic [11:0] coef,
    output logic      [31:0] term
);
    logic signed [27:0] product;

    // full 28-bit product, two integer bits
    assign product = $signed(sample) * $signed(coef);
    // drop four lsbs, extend 24 bits to 32
    assign term = {{8{product[27]}}, product[27:4]};
endmodule

//--- tb/fmfc_source_model.sv
// upstream sample source and shared go line for one device
module fmfc_source_model (
    input  wire logic        ref_clk,
    input  wire logic        reset,
    input  wire logic        goRequest,
    input  wire logic [15:0] sample,
    input  wire logic [31:0] sum,
    output logic      [15:0] dataIn,
    output logic      [15:0] casDataIn,
    output logic      [31:0] casSumIn,
    output logic             filterGoInput
);
    timeunit 1ns;
    timeprecision 1ps;

    logic streaming;

    // go stays low until asked, then rises with the first valid sample and stays up
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            streaming     <= 1'b0;
            filterGoInput <= 1'b0;
            dataIn        <= 16'h5a5a;
            casDataIn     <= 16'ha5a5;
            casSumIn      <= 32'h0;
        end else if (streaming || goRequest) begin
            streaming     <= 1'b1;
            filterGoInput <= 1'b1;
            dataIn        <= sample;
            casDataIn     <= sample;
            casSumIn      <= sum;
        end else begin
            dataIn    <= ~dataIn; // no valid sample yet
            casDataIn <= ~casDataIn;
            casSumIn  <= ~casSumIn;
        end
    end
endmodule

//--- tb/fmfc_core_test.sv
`define CHECK(what, expv, gotv) \
    begin \
        nTests++; \
        if ((gotv) !== (expv)) begin \
            fails++; \
            $display("mismatch %s expected %h seen %h", what, expv, gotv); \
        end \
    end

module fmfc_core_test;
    timeunit 1ns;
    timeprecision 1ps;

    logic        ref_clk, reset, controlWrite, coefWrite, loadDone, romLoadSelect;
    logic        freeStartSelect, filterGoInput, swapPin, goRequest;
    logic [15:0] controlData, coefData, dataIn, casDataIn, sample;
    logic [6:0]  coefAddr;
    logic [31:0] casSumIn, sum, resultOut;
    logic [15:0] casDataOut, controlOut;
    logic        sampleStrobeOut, delayedGoOutput, running, configError, bankActive;
    int          fails, nTests;

    fmfc_core u_dut (
        .ref_clk(ref_clk), .reset(reset), .controlWrite(controlWrite),
        .controlData(controlData), .coefWrite(coefWrite), .coefAddr(coefAddr),
        .coefData(coefData), .loadDone(loadDone), .romLoadSelect(romLoadSelect),
        .freeStartSelect(freeStartSelect), .filterGoInput(filterGoInput),
        .swapPin(swapPin), .dataIn(dataIn), .casDataIn(casDataIn), .casSumIn(casSumIn),
        .resultOut(resultOut), .casDataOut(casDataOut), .sampleStrobeOut(sampleStrobeOut),
        .delayedGoOutput(delayedGoOutput), .running(running), .configError(configError),
        .bankActive(bankActive), .controlOut(controlOut)
    );

    fmfc_source_model u_src (
        .ref_clk(ref_clk), .reset(reset), .goRequest(goRequest), .sample(sample),
        .sum(sum), .dataIn(dataIn), .casDataIn(casDataIn), .casSumIn(casSumIn),
        .filterGoInput(filterGoInput)
    );

    // 100 MHz clock
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    // expected coefficient after rounding toward zero
    function automatic logic [11:0] roundCoef(input logic [15:0] c);
        return c[15] ? c[15:4] + {11'h0, |c[3:0]} : c[15:4];
    endfunction

    // expected accumulator term: full product, low four bits dropped, sign extended
    function automatic logic [31:0] termOf(input logic [15:0] d, input logic [11:0] c);
        logic signed [27:0] p;
        p = $signed(d) * $signed(c);
        return {{8{p[27]}}, p[27:4]};
    endfunction

    task automatic summarize();
        $display("checks %0d mismatches %0d", nTests, fails);
        if (fails == 0 && nTests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic cycles(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    // bounded wait for one status output to reach a level
    task automatic waitFor(input string what, input int sel, input logic val, input int bound);
        logic seen;
        seen = ~val;
        for (int i = 0; i < bound && seen !== val; i++) begin
            @(posedge ref_clk);
            #1;
            case (sel)
                0: seen = running;
                1: seen = delayedGoOutput;
                default: seen = bankActive;
            endcase
        end
        `CHECK(what, val, seen)
        if (seen !== val) begin
            summarize();
        end
    endtask

    task automatic resetDut();
        @(posedge ref_clk);
        reset     <= 1'b1;
        goRequest <= 1'b0;
        loadDone  <= 1'b0;
        cycles(16);
        @(posedge ref_clk);
        reset <= 1'b0;
        #1;
    endtask

    task automatic writeCtrl(input logic [15:0] v);
        @(posedge ref_clk);
        controlWrite <= 1'b1;
        controlData  <= v;
        @(posedge ref_clk);
        controlWrite <= 1'b0;
        cycles(3);
    endtask

    task automatic writeCoef(input logic [6:0] a, input logic [15:0] v);
        @(posedge ref_clk);
        coefWrite <= 1'b1;
        coefAddr  <= a;
        coefData  <= v;
        @(posedge ref_clk);
        coefWrite <= 1'b0;
    endtask

    task automatic testReset();
        resetDut();
        `CHECK("controlOut", 16'h8c80, controlOut)
        `CHECK("running", 1'b0, running)
        `CHECK("resultOut", 32'h0, resultOut)
        `CHECK("bankActive", 1'b0, bankActive)
        `CHECK("configError", 1'b0, configError)
    endtask

    // tap, decimate and bank combinations against storage size
    task automatic testOptions();
        logic [15:0] ctl [7] = '{16'hecc0, 16'hdc80, 16'hccc0, 16'hdcc0, 16'hbcc0, 16'hacc0,
                                 16'hfc80};
        logic        err [7] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1};
        for (int i = 0; i < 7; i++) begin
            writeCtrl(ctl[i]);
            `CHECK("controlOut", ctl[i], controlOut)
            `CHECK("configError", err[i], configError)
        end
        writeCtrl(16'h8c80);
    endtask

    task automatic testStart();
        for (int a = 0; a < 128; a++) begin
            writeCoef(7'(a), 16'h0);
        end
        @(posedge ref_clk);
        loadDone <= 1'b1;
        cycles(8);
        `CHECK("running", 1'b0, running)
        @(posedge ref_clk);
        goRequest <= 1'b1;
        waitFor("running", 0, 1'b1, 8);
        waitFor("delayedGoOutput", 1, 1'b1, 6);
    endtask

    task automatic testArith();
        logic [15:0] d [3] = '{16'h8000, 16'h1234, 16'hff00};
        logic [15:0] c [3] = '{16'h8005, 16'h7fff, 16'hfff0};
        for (int i = 0; i < 3; i++) begin
            writeCoef(7'h0, c[i]);
            sample <= d[i];
            cycles(40);
            `CHECK("resultOut", termOf(d[i], roundCoef(c[i])), resultOut)
        end
    endtask

    task automatic testCascade();
        logic [31:0] netA;
        sum <= 32'h0001_0000;
        writeCtrl(16'h8080);
        cycles(40);
        `CHECK("resultOut", 32'h0001_0000 + termOf(sample, 12'hfff), resultOut)
        `CHECK("casDataOut", sample, casDataOut)
        // termination at full rate: pins in, no neighbour sum, pipelined result
        writeCtrl(16'h8480);
        cycles(40);
        `CHECK("resultOut", termOf(sample, 12'hfff), resultOut)
        // dual cascaded: network two filters the middle bits of network one
        writeCoef(7'h00, 16'h7ff0);
        writeCoef(7'h40, 16'h7ff0);
        writeCtrl(16'h0c90);
        cycles(40);
        netA = termOf(sample, 12'h7ff);
        `CHECK("resultOut", termOf(netA[23:8], 12'h7ff), resultOut)
        writeCtrl(16'h8c80);
    endtask

    task automatic testStrobe();
        int n;
        n = 0;
        writeCtrl(16'hecc0);
        cycles(20);
        repeat (64) begin
            cycles(1);
            n += (sampleStrobeOut === 1'b1);
        end
        `CHECK("strobeCount", 8, n)
        `CHECK("bankActive", 1'b0, bankActive)
        `CHECK("configError", 1'b1, configError)
        writeCtrl(16'h8c80);
    endtask

    task automatic testBank();
        writeCtrl(16'h8cc0);
        waitFor("bankActive", 2, 1'b1, 10);
        swapPin <= 1'b0;
        writeCtrl(16'h8c00);
        waitFor("bankActive", 2, 1'b0, 12);
        @(posedge ref_clk);
        swapPin <= 1'b1;
        waitFor("bankActive", 2, 1'b1, 12);
    endtask

    task automatic testFreeRun();
        romLoadSelect   <= 1'b1;
        freeStartSelect <= 1'b1;
        resetDut();
        @(posedge ref_clk);
        loadDone <= 1'b1;
        waitFor("running", 0, 1'b1, 8);
        `CHECK("filterGoInput", 1'b0, filterGoInput)
    endtask

    initial begin
        fails = 0;
        nTests = 0;
        reset = 1'b1;
        controlWrite = 1'b0;
        controlData = 16'h0;
        coefWrite = 1'b0;
        coefAddr = 7'h0;
        coefData = 16'h0;
        loadDone = 1'b0;
        romLoadSelect = 1'b0;
        freeStartSelect = 1'b0;
        swapPin = 1'b0;
        goRequest = 1'b0;
        sample = 16'h0;
        sum = 32'h0;
        testReset();
        testOptions();
        testStart();
        testArith();
        testCascade();
        testStrobe();
        testBank();
        testFreeRun();
        summarize();
    end
endmodule
